/* canab_regs.vh */
// Purpose: constants for the transmit abort, buffer select
//          and acceptance control register block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   registers are 8 bits wide in the low byte
`ifndef CANAB_REGS_VH
`define CANAB_REGS_VH

// register byte offsets
`define CANAB_OFS_TAAK 12'h000
`define CANAB_OFS_TBSEL 12'h004
`define CANAB_OFS_IDAC 12'h008
`define CANAB_OFS_RSVD 12'h00c
`define CANAB_OFS_RXERR 12'h010
`define CANAB_OFS_TFLG 12'h014
`define CANAB_OFS_TARQ 12'h018

// field widths and positions
`define CANAB_NBUF 3
`define CANAB_MODE_W 2
`define CANAB_HIT_W 3
`define CANAB_CNT_W 8
`define CANAB_ACCEPTANCE_MODE_FIELD_LO 4
`define CANAB_ACCEPTANCE_MODE_FIELD_HI 5
`define CANAB_HIT_LO 0
`define CANAB_HIT_HI 2
`define CANAB_BUF_HI 2
`define CANAB_BUF_LO 0
`define CANAB_CNT_HI 7
`define CANAB_CNT_LO 0

// acceptance mode encodings
`define CANAB_AM_TWO32 2'h0
`define CANAB_AM_FOUR16 2'h1
`define CANAB_AM_EIGHT8 2'h2
`define CANAB_AM_CLOSED 2'h3

// hit index masks per mode
`define CANAB_HMASK_TWO 3'h1
`define CANAB_HMASK_FOUR 3'h3
`define CANAB_HMASK_EIGHT 3'h7

// reset values
`define CANAB_RST_TXE 3'h7
`define CANAB_RST_ZERO3 3'h0
`define CANAB_RST_MODE 2'h0
`define CANAB_RST_CNT 8'h00
`define CANAB_RST_DATA 32'h00000000

`endif

/* canab_top.v */
// Purpose: transmit abort acknowledge, transmit buffer select,
//          acceptance mode and hit, receive error counter view
// Assumes: APB3 slave on SYS_CLK; scheduler, filter engine and
//          mode handshakes on the same clock, no synchronisers
//          TX_STARTED is a level while a buffer is on the bus,
//          TX_SENT_OK and TX_FAILED are one-cycle pulses
//          RX_MATCH and RX_SHIFT are one-cycle pulses
// Notes:   one wait state on every APB access; PREADY and PSLVERR
//          stand for a single cycle, PRDATA holds until the next access
//          register map, byte offsets, fields in bits 7:0:
//            0x00 abort acknowledge flags, read-only
//            0x04 transmit buffer select, lowest set bit wins
//            0x08 acceptance mode in 5:4, filter hit in 2:0
//            0x0c reserved, always reads zero
//            0x10 receive error count copy, read-only
//            0x14 empty flags, write one to schedule a buffer
//            0x18 abort requests, write one while scheduled
//          unmapped offsets answer with PSLVERR and zero data
//          empty flags are not touched by init mode
//          a send and a grant in one cycle: the send wins
//          error count is only trustworthy in sleep or init
//          CLK_EN low freezes every flop, the APB answer too
// Summary of operation
// - abort ack set when abort granted
// - abort ack cleared with empty flag
// - abort ack held reset in init
// - abort ack read-only, writes ignored
// - lowest select bit maps window buffer
// - select read shows lowest set bit
// - window blocked while buffer scheduled
// - no window access without selection
// - select reset in init, written outside
// - mode field picks filter organisation
// - closed filter accepts no message
// - hit field gives matching filter number
// - hit follows foreground buffer shifts
// - mode written in init, hit read-only
// - reserved register reads zero, ignores writes
// - receive error count read-only view
// - empty flag set on send or abort
// - abort granted only before start or failure
`timescale 1ns/1ps
`include "canab_regs.vh"

module canab_top (
   // clock and reset
   input wire SYS_CLK,
   input wire SYS_RST,
   input wire CLK_EN,
   // apb slave
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   output reg PREADY,
   output reg [31:0] PRDATA,
   output reg PSLVERR,
   // mode handshakes
   input wire INIT_REQ,
   input wire INIT_ACK,
   input wire SLEEP_REQ,
   input wire SLEEP_ACK,
   // transmit scheduler
   input wire [2:0] TX_STARTED,
   input wire [2:0] TX_SENT_OK,
   input wire [2:0] TX_FAILED,
   output reg [2:0] TX_EMPTY,
   output reg [2:0] TX_ABORT_REQ,
   output reg [2:0] TX_ABORT_ACK,
   output reg [2:0] TX_WIN_SEL,
   output reg TX_WIN_OPEN,
   // receive side
   input wire RX_MATCH,
   input wire [2:0] RX_MATCH_IDX,
   input wire RX_SHIFT,
   input wire [7:0] RX_ERR_CNT,
   output reg RX_ACCEPT,
   output reg [1:0] FILTER_MODE,
   output reg [2:0] FILTER_HIT,
   output reg SLEEP_OR_INIT
);

   // lowest set bit of a buffer mask
   function [2:0] lowest_bit;
      input [2:0] v;
      begin
         if (v[0]) begin
            lowest_bit = 3'h1;
         end else if (v[1]) begin
            lowest_bit = 3'h2;
         end else if (v[2]) begin
            lowest_bit = 3'h4;
         end else begin
            lowest_bit = 3'h0;
         end
      end
   endfunction

   // filter number limited to the filters of a mode
   function [2:0] hit_mask;
      input [1:0] mode;
      input [2:0] idx;
      begin
         case (mode)
            `CANAB_AM_TWO32: begin
               hit_mask = idx & `CANAB_HMASK_TWO;
            end
            `CANAB_AM_FOUR16: begin
               hit_mask = idx & `CANAB_HMASK_FOUR;
            end
            default: begin
               hit_mask = idx & `CANAB_HMASK_EIGHT;
            end
         endcase
      end
   endfunction

   // mode decode
   // mixed handshake states count as neither mode
   wire init_mode;
   wire not_init;
   assign init_mode = INIT_REQ & INIT_ACK;
   assign not_init = ~INIT_REQ & ~INIT_ACK;

   // apb phase decode
   // PREADY high marks the second access cycle
   wire apb_acc;
   wire apb_first;
   wire apb_done;
   wire apb_wr;
   assign apb_acc = PSEL & PENABLE;
   assign apb_first = apb_acc & ~PREADY;
   assign apb_done = apb_acc & PREADY;
   assign apb_wr = apb_done & PWRITE;

   // write strobes per register
   wire wr_tbsel;
   wire wr_idac;
   wire wr_tflg;
   wire wr_tarq;
   assign wr_tbsel = apb_wr & (PADDR == `CANAB_OFS_TBSEL);
   assign wr_idac = apb_wr & (PADDR == `CANAB_OFS_IDAC);
   assign wr_tflg = apb_wr & (PADDR == `CANAB_OFS_TFLG);
   assign wr_tarq = apb_wr & (PADDR == `CANAB_OFS_TARQ);
   // no strobe at all for the
   // acknowledge, reserved and error count offsets

   // state
   reg [2:0] txe_q;
   reg [2:0] arq_q;
   reg [2:0] abort_ack_flag_q;
   reg [2:0] tbsel_q;
   reg [1:0] acceptance_mode_field_q;
   reg [2:0] hit_q;
   reg [2:0] pend_hit_q;
   reg [7:0] rxerr_q;

   // filter closed and sleep decode
   wire closed_mode;
   wire sleep_mode;
   assign closed_mode = (acceptance_mode_field_q == `CANAB_AM_CLOSED);
   assign sleep_mode = SLEEP_REQ & SLEEP_ACK;

   // per-buffer events
   wire [2:0] grant;
   wire [2:0] txe_set;
   wire [2:0] txe_clr;
   wire [2:0] txe_d;
   wire [2:0] arq_d;
   wire [2:0] abort_ack_flag_d;

   // per-buffer flag logic; the hardware event
   // always beats a cpu write in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < `CANAB_NBUF; gi = gi + 1) begin : g_buf
         // abort only before start or after failure
         assign grant[gi] = arq_q[gi] & ~txe_q[gi] & ~TX_SENT_OK[gi]
                            & (~TX_STARTED[gi] | TX_FAILED[gi]);
         // empty on send or granted abort
         assign txe_set[gi] = ~txe_q[gi] & (TX_SENT_OK[gi] | grant[gi]);
         // cpu writes one to schedule a full buffer
         assign txe_clr[gi] = wr_tflg & PWDATA[gi] & txe_q[gi];
         assign txe_d[gi] = txe_set[gi] ? 1'b1 :
                            (txe_clr[gi] ? 1'b0 : txe_q[gi]);
         // request dropped when the buffer empties
         assign arq_d[gi] = init_mode ? 1'b0 :
                            (txe_set[gi] ? 1'b0 :
                            ((wr_tarq & not_init & PWDATA[gi] & ~txe_q[gi])
                            ? 1'b1 : arq_q[gi]));
         // ack set by a granted abort
         // ack cleared when empty flag clears
         // ack held reset in init mode
         assign abort_ack_flag_d[gi] = init_mode ? 1'b0 :
                              (grant[gi] ? 1'b1 :
                              (txe_clr[gi] ? 1'b0 : abort_ack_flag_q[gi]));
      end
   endgenerate

   // transmit flag registers
   // init clears acks and requests, not empties
   always @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         txe_q <= `CANAB_RST_TXE;
         arq_q <= `CANAB_RST_ZERO3;
         abort_ack_flag_q <= `CANAB_RST_ZERO3;
      end else if (CLK_EN) begin
         txe_q <= txe_d;
         arq_q <= arq_d;
         abort_ack_flag_q <= abort_ack_flag_d;
      end
   end

   // buffer select register
   always @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         tbsel_q <= `CANAB_RST_ZERO3;
      end else if (CLK_EN) begin
         // reset in init, written outside it
         if (init_mode) begin
            tbsel_q <= `CANAB_RST_ZERO3;
         end else if (wr_tbsel & not_init) begin
            tbsel_q <= PWDATA[`CANAB_BUF_HI:`CANAB_BUF_LO];
         end
      end
   end

   // acceptance control and hit tracking
   always @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         acceptance_mode_field_q <= `CANAB_RST_MODE;
         hit_q <= `CANAB_RST_ZERO3;
         pend_hit_q <= `CANAB_RST_ZERO3;
      end else if (CLK_EN) begin
         if (wr_idac & init_mode) begin
            acceptance_mode_field_q <= PWDATA[`CANAB_ACCEPTANCE_MODE_FIELD_HI:`CANAB_ACCEPTANCE_MODE_FIELD_LO];
         end
         // filter number of the accepted frame
         if (RX_MATCH & ~closed_mode) begin
            pend_hit_q <= hit_mask(acceptance_mode_field_q, RX_MATCH_IDX);
         end
         if (RX_SHIFT & ~closed_mode) begin
            hit_q <= pend_hit_q;
         end
      end
   end

   // receive error counter copy
   always @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rxerr_q <= `CANAB_RST_CNT;
      end else if (CLK_EN) begin
         rxerr_q <= RX_ERR_CNT;
      end
   end

   // read mux and address map
   // unmapped offsets raise PSLVERR
   reg [31:0] rd_val;
   reg mapped;
   always @* begin
      rd_val = `CANAB_RST_DATA;
      mapped = 1'b1;
      case (PADDR)
         `CANAB_OFS_TAAK: begin
            rd_val[`CANAB_BUF_HI:`CANAB_BUF_LO] = abort_ack_flag_q;
         end
         `CANAB_OFS_TBSEL: begin
            rd_val[`CANAB_BUF_HI:`CANAB_BUF_LO] = lowest_bit(tbsel_q);
         end
         `CANAB_OFS_IDAC: begin
            rd_val[`CANAB_ACCEPTANCE_MODE_FIELD_HI:`CANAB_ACCEPTANCE_MODE_FIELD_LO] = acceptance_mode_field_q;
            rd_val[`CANAB_HIT_HI:`CANAB_HIT_LO] = hit_q;
         end
         `CANAB_OFS_RSVD: begin
            rd_val = `CANAB_RST_DATA;
         end
         `CANAB_OFS_RXERR: begin
            rd_val[`CANAB_CNT_HI:`CANAB_CNT_LO] = rxerr_q;
         end
         `CANAB_OFS_TFLG: begin
            rd_val[`CANAB_BUF_HI:`CANAB_BUF_LO] = txe_q;
         end
         `CANAB_OFS_TARQ: begin
            rd_val[`CANAB_BUF_HI:`CANAB_BUF_LO] = arq_q;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // apb answer, one wait state
   always @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         PREADY <= 1'b0;
         PRDATA <= `CANAB_RST_DATA;
         PSLVERR <= 1'b0;
      end else if (CLK_EN) begin
         PREADY <= apb_first;
         if (apb_first) begin
            // reads take the mux, writes answer zero
            PRDATA <= PWRITE ? `CANAB_RST_DATA : rd_val;
            PSLVERR <= ~mapped;
         end else begin
            PSLVERR <= 1'b0;
         end
      end
   end

   // window selection and access gate
   wire [2:0] sel_now;
   wire sel_busy;
   assign sel_now = lowest_bit(tbsel_q);
   // a scheduled selected buffer keeps the window shut
   assign sel_busy = |(sel_now & ~txe_q);

   // transmit outputs
   always @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         TX_EMPTY <= `CANAB_RST_TXE;
         TX_ABORT_REQ <= `CANAB_RST_ZERO3;
         TX_ABORT_ACK <= `CANAB_RST_ZERO3;
         TX_WIN_SEL <= `CANAB_RST_ZERO3;
         TX_WIN_OPEN <= 1'b0;
      end else if (CLK_EN) begin
         TX_EMPTY <= txe_d;
         TX_ABORT_REQ <= arq_d;
         TX_ABORT_ACK <= abort_ack_flag_d;
         TX_WIN_SEL <= sel_now;
         TX_WIN_OPEN <= (|sel_now) & ~sel_busy;
      end
   end

   // receive outputs
   always @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         RX_ACCEPT <= 1'b0;
         FILTER_MODE <= `CANAB_RST_MODE;
         FILTER_HIT <= `CANAB_RST_ZERO3;
         SLEEP_OR_INIT <= 1'b0;
      end else if (CLK_EN) begin
         FILTER_MODE <= acceptance_mode_field_q;
         RX_ACCEPT <= RX_MATCH & ~closed_mode;
         FILTER_HIT <= hit_q;
         // marks when counter reads are valid
         SLEEP_OR_INIT <= init_mode | sleep_mode;
      end
   end

endmodule

/* canab_checker.sv */
// Purpose: port assertions for canab_top
// Assumes: one clock domain, CLK_EN held high
// Notes:   bound onto every canab_top
`timescale 1ns/1ps
module canab_checker (
   // clock, reset and apb
   input wire SYS_CLK,
   input wire SYS_RST,
   input wire PSEL,
   input wire PENABLE,
   input wire PREADY,
   input wire PSLVERR,
   input wire [31:0] PRDATA,
   // mode, transmit and receive
   input wire INIT_REQ,
   input wire INIT_ACK,
   input wire TX_WIN_OPEN,
   input wire RX_MATCH,
   input wire RX_ACCEPT,
   input wire [2:0] TX_ABORT_ACK,
   input wire [2:0] TX_WIN_SEL,
   input wire [1:0] FILTER_MODE
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   // init clears acknowledge and selection
   a_ack_init: assert property ((INIT_REQ && INIT_ACK) [*3] |-> TX_ABORT_ACK == 3'h0) else $error("ack in init");
   a_sel_init: assert property ((INIT_REQ && INIT_ACK) [*3] |-> TX_WIN_SEL == 3'h0) else $error("sel in init");
   // window mapping
   a_sel_onehot: assert property ($onehot0(TX_WIN_SEL)) else $error("window not one-hot");
   a_win_none: assert property (TX_WIN_OPEN |-> TX_WIN_SEL != 3'h0) else $error("open unselected");
   // acceptance follows mode, closed takes nothing
   a_accept_mode: assert property (RX_MATCH |=> RX_ACCEPT == (FILTER_MODE != 2'h3)) else $error("accept");
   a_accept_cause: assert property (RX_ACCEPT |-> $past(RX_MATCH)) else $error("stray accept");
   // apb answers
   a_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h0) else $error("upper bits");
   a_err_data: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0) else $error("error data");
   a_ready_time: assert property (PSEL && !PENABLE |-> ##[1:3] PREADY) else $error("no answer");
endmodule
bind canab_top canab_checker chk_i (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA), .INIT_REQ(INIT_REQ),
   .INIT_ACK(INIT_ACK), .TX_WIN_OPEN(TX_WIN_OPEN), .RX_MATCH(RX_MATCH), .RX_ACCEPT(RX_ACCEPT),
   .TX_ABORT_ACK(TX_ABORT_ACK), .TX_WIN_SEL(TX_WIN_SEL), .FILTER_MODE(FILTER_MODE));

/* canab_engine.sv */
// Purpose: protocol engine model, scheduler and receive side
// Assumes: driven through its tasks by the bench
// Notes:   released index shows the inverse value
`timescale 1ns/1ps
module canab_engine (
   // clock
   input wire sys_clk,
   // engine outputs
   output logic [2:0] tx_started,
   output logic [2:0] tx_sent_ok,
   output logic [2:0] tx_failed,
   output logic [2:0] rx_match_idx,
   output logic rx_match,
   output logic rx_shift,
   output logic [7:0] rx_err_cnt
);
   // idle state
   initial begin
      {tx_started, tx_sent_ok, tx_failed, rx_match_idx, rx_match, rx_shift} = 0;
      rx_err_cnt = 8'h05;
   end
   // transmission in progress level
   task start(input int i);
      @(posedge sys_clk);
      tx_started[i] <= 1'b1;
   endtask
   // end of transmission, success or lost arbitration
   task done(input int i, input logic ok);
      @(posedge sys_clk);
      tx_sent_ok[i] <= ok;
      tx_failed[i] <= !ok;
      @(posedge sys_clk);
      {tx_sent_ok, tx_failed} <= 6'h0;
      tx_started[i] <= 1'b0;
   endtask
   // match, then shift into the foreground buffer
   task frame(input logic [2:0] idx);
      @(posedge sys_clk);
      rx_match <= 1'b1;
      rx_match_idx <= idx;
      @(posedge sys_clk);
      rx_match <= 1'b0;
      rx_shift <= 1'b1;
      @(posedge sys_clk);
      rx_shift <= 1'b0;
      rx_match_idx <= ~idx;
      rx_err_cnt <= rx_err_cnt + 8'h03;
   endtask
endmodule

/* tb.sv */
// Purpose: self-checking bench for canab_top
// Assumes: apb master tasks, answers checked from a queue
// Notes:   engine model supplies scheduler and receive events
`timescale 1ns/1ps
`include "canab_regs.vh"
module tb;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [3:0] modes = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, d;
   logic [32:0] q[$];
   logic [2:0] h, v;
   wire pready, pslverr, wopen, racc, soi, rmatch, rshift;
   wire [31:0] prdata;
   wire [2:0] tx_buffer_empty_flag, tarq, tack, wsel, fhit, tst, tok, tfl, ridx;
   wire [1:0] fmode;
   wire [7:0] rerr;
   int bad_count = 0, cmp_count = 0, m;
   canab_engine eng (.sys_clk(clk), .tx_started(tst), .tx_sent_ok(tok), .tx_failed(tfl),
      .rx_match_idx(ridx), .rx_match(rmatch), .rx_shift(rshift), .rx_err_cnt(rerr));
   canab_top dut (.SYS_CLK(clk), .SYS_RST(rst), .CLK_EN(1'b1), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
      .PSLVERR(pslverr), .INIT_REQ(modes[3]), .INIT_ACK(modes[2]), .SLEEP_REQ(modes[1]),
      .SLEEP_ACK(modes[0]), .TX_STARTED(tst), .TX_SENT_OK(tok), .TX_FAILED(tfl), .TX_EMPTY(tx_buffer_empty_flag),
      .TX_ABORT_REQ(tarq), .TX_ABORT_ACK(tack), .TX_WIN_SEL(wsel), .TX_WIN_OPEN(wopen),
      .RX_MATCH(rmatch), .RX_MATCH_IDX(ridx), .RX_SHIFT(rshift), .RX_ERR_CNT(rerr),
      .RX_ACCEPT(racc), .FILTER_MODE(fmode), .FILTER_HIT(fhit), .SLEEP_OR_INIT(soi));
   initial forever #10 clk = ~clk;
   // oldest note against each completed transfer
   always @(posedge clk) begin
      if (pready === 1'b1) begin
         cmp_count++;
         if (q.size() == 0 || {pslverr, prdata} !== q[0]) begin
            bad_count++;
            $display("[FAIL] %0t answer %h", $time, {pslverr, prdata});
         end
         if (q.size() != 0) void'(q.pop_front());
      end
   end
   // one apb transfer, held until pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] e);
      int n;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
      q.push_back(e);
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         $display("[FAIL] %0t no ready", $time);
      end
      {psel, penable} <= 2'b00;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd, 33'h0);
   endtask
   task rd(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0, {25'h0, e});
   endtask
   // mode handshake levels: init req, ack, sleep req, ack
   task md(input logic [3:0] s);
      @(posedge clk);
      modes <= s;
      repeat (3) @(posedge clk);
   endtask
   task chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t output %h, expected %h", $time, g, e);
      end
   endtask
   task test_done;
      $display("counts: %0d compared, %0d mismatched", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog
   initial begin
      #200000;
      bad_count++;
      test_done;
   end
   initial begin
      void'($urandom(32'h44a2bf08));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(`CANAB_OFS_TAAK, 8'h00);
      rd(`CANAB_OFS_IDAC, 8'h00);
      rd(`CANAB_OFS_TFLG, 8'h07);
      apb(1'b0, 12'h01c, 32'h0, {1'b1, 32'h0});
      $display("test reset values done");
      // every mode written in init, one frame each
      md(4'hc);
      chk(soi, 1'b1);
      h = 3'h0;
      for (m = 0; m < 4; m++) begin
         wr(`CANAB_OFS_IDAC, 32'hffffffcf | (m << 4));
         v = 3'($urandom);
         eng.frame(v);
         if (m != 3) h = v & ((m == 0) ? 3'h1 : (m == 1) ? 3'h3 : 3'h7);
         rd(`CANAB_OFS_IDAC, {2'h0, m[1:0], 1'b0, h});
         chk(fmode, m[1:0]);
         chk(fhit, h);
      end
      wr(`CANAB_OFS_RXERR, 32'hff);
      rd(`CANAB_OFS_RXERR, rerr);
      md(4'h3);
      chk(soi, 1'b1);
      wr(`CANAB_OFS_IDAC, 32'h0);
      rd(`CANAB_OFS_IDAC, {4'h3, 1'b0, h});
      rd(`CANAB_OFS_RXERR, rerr);
      md(4'h0);
      chk(soi, 1'b0);
      $display("test filter done");
      wr(`CANAB_OFS_TBSEL, 32'h1);
      repeat (3) @(posedge clk);
      chk(wopen, 1'b1);
      wr(`CANAB_OFS_TFLG, 32'h7);
      repeat (3) @(posedge clk);
      chk(wopen, 1'b0);
      eng.start(1);
      eng.start(2);
      wr(`CANAB_OFS_TARQ, 32'h7);
      repeat (2) @(posedge clk);
      chk(tarq, 3'h6);
      chk(tack, 3'h1);
      eng.done(1, 1'b1);
      eng.done(2, 1'b0);
      rd(`CANAB_OFS_TAAK, 8'h05);
      rd(`CANAB_OFS_TFLG, 8'h07);
      chk(tx_buffer_empty_flag, 3'h7);
      chk(tarq, 3'h0);
      wr(`CANAB_OFS_TAAK, 32'hff);
      rd(`CANAB_OFS_TAAK, 8'h05);
      wr(`CANAB_OFS_TFLG, 32'h1);
      rd(`CANAB_OFS_TAAK, 8'h04);
      wr(`CANAB_OFS_RSVD, 32'hff);
      rd(`CANAB_OFS_RSVD, 8'h00);
      $display("test transmit done");
      for (m = 0; m < 8; m++) begin
         d = $urandom;
         wr(`CANAB_OFS_TBSEL, d);
         rd(`CANAB_OFS_TBSEL, {5'h0, d[2:0] & (~d[2:0] + 3'h1)});
      end
      wr(`CANAB_OFS_TBSEL, 32'h4);
      md(4'hc);
      rd(`CANAB_OFS_TAAK, 8'h00);
      wr(`CANAB_OFS_TBSEL, 32'h7);
      rd(`CANAB_OFS_TBSEL, 8'h00);
      $display("test select and init done");
      test_done;
   end
endmodule
